// ===== shared/vic_pkg.sv
// Behaviour
// RL1: falling edge on pin sets external flag
// RL2: external sources call 04h or 08h
// RL3: external vectoring clears flag and master enable
// RL4: timer 0 overflow flags, calls 0ch
// RL5: timer 1 flag bit 4, calls 10h
// RL6: time base flag bit 5, calls 14h
// RL7: rtc flag bit 6, calls 18h
// RL8: acknowledgments held until return or re-enable
// RL9: irq return sets master enable, plain not
// RL10: requests serviced on next phase-two edge
// RL11: fixed priority ext0 highest, rtc lowest
// RL12: master enable clear masks all sources
// RL13: control 0 bit layout, bit 7 zero
// RL14: control 1 bit layout, bits 3,7 zero
// RL15: registers at 0bh and 1eh, read/write
// RL16: flags stay set until serviced or cleared
// RL17: disabled source still records its flag
// RL18: vector only when enabled, stack room, active
// RL19: full stack blocks every acknowledgment
// RL20: only program counter pushed on acknowledge
// RL21: only serviced source flag is cleared
package vic_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] VIC_ADDR_CTRL0 = 8'h0b;
  localparam logic [7:0] VIC_ADDR_CTRL1 = 8'h1e;
  localparam logic [7:0] VIC_CTRL_RESET = 8'h00;
  // control 0 fields
  localparam int VIC_C0_MASTER_EN = 0;
  localparam int VIC_C0_EXT0_EN = 1;
  localparam int VIC_C0_EXT1_EN = 2;
  localparam int VIC_C0_TMR0_EN = 3;
  localparam int VIC_C0_EXT0_FLAG = 4;
  localparam int VIC_C0_EXT1_FLAG = 5;
  localparam int VIC_C0_TMR0_FLAG = 6;
  // control 1 fields
  localparam int VIC_C1_TMR1_EN = 0;
  localparam int VIC_C1_TB_EN = 1;
  localparam int VIC_C1_RTC_EN = 2;
  localparam int VIC_C1_TMR1_FLAG = 4;
  localparam int VIC_C1_TB_FLAG = 5;
  localparam int VIC_C1_RTC_FLAG = 6;
  // ----------------------------------------
  // vectors, priority order index 0 first
  // ----------------------------------------
  localparam int VIC_NSRC = 6;
  localparam logic [11:0] VIC_VEC_EXT0 = 12'h004;
  localparam logic [11:0] VIC_VEC_EXT1 = 12'h008;
  localparam logic [11:0] VIC_VEC_TMR0 = 12'h00c;
  localparam logic [11:0] VIC_VEC_TMR1 = 12'h010;
  localparam logic [11:0] VIC_VEC_TB = 12'h014;
  localparam logic [11:0] VIC_VEC_RTC = 12'h018;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } vic_bus_s;

  typedef struct packed {
    logic req;
    logic [11:0] vector;
    logic [2:0] src;
  } vic_call_s;
endpackage

// ===== src/vic_pri_pick.sv
`timescale 1ns/1ps
module vic_pri_pick #(
  parameter int N = 6
) (
  // requests, bit 0 highest
  input wire logic [N-1:0] req_in,
  // result
  output logic any_out,
  output logic [N-1:0] onehot_out,
  output logic [2:0] index_out
);
  always_comb begin
    any_out = 1'b0;
    onehot_out = '0;
    index_out = 3'h0;
    // fixed priority scan, lowest index wins
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin // see RL11
        any_out = 1'b1;
        onehot_out = '0;
        onehot_out[i] = 1'b1;
        index_out = 3'(i);
      end
    end
  end
endmodule // vic_pri_pick

// ===== src/vic_ctrl.sv
`timescale 1ns/1ps
module vic_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // data memory port
  input wire vic_pkg::vic_bus_s bus_in,
  output logic [7:0] rdata_out,
  // sequencer
  input wire logic phase_two_clock_in,
  input wire logic stack_full_in,
  input wire logic irq_return_instr_in,
  input wire logic plain_return_instr_in,
  input wire logic call_done_in,
  output vic_pkg::vic_call_s call_out,
  // event sources
  input wire logic ext_irq_pin_a_in,
  input wire logic ext_irq_pin_b_in,
  input wire logic timer0_ovf_in,
  input wire logic timer1_ovf_in,
  input wire logic timebase_tick_in,
  input wire logic rtc_tick_in
);
  import vic_pkg::*;

  typedef struct packed {
    logic master_irq_enable;
    logic [VIC_NSRC-1:0] en;
    logic [VIC_NSRC-1:0] flag;
    logic pin_a_d;
    logic pin_b_d;
    logic t2_d;
    vic_call_s call;
  } vic_state_s;

  vic_state_s st_r, st_nxt;
  logic [VIC_NSRC-1:0] set_ev;
  logic [VIC_NSRC-1:0] elig;
  logic [VIC_NSRC-1:0] pick;
  logic pick_any;
  logic [2:0] pick_idx;
  logic t2_rise;
  logic [7:0] c0, c1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [11:0] vec_of(input logic [2:0] idx);
    unique case (idx)
      3'h0: vec_of = VIC_VEC_EXT0; // see RL2
      3'h1: vec_of = VIC_VEC_EXT1; // see RL2
      3'h2: vec_of = VIC_VEC_TMR0; // see RL4
      3'h3: vec_of = VIC_VEC_TMR1; // see RL5
      3'h4: vec_of = VIC_VEC_TB; // see RL6
      3'h5: vec_of = VIC_VEC_RTC; // see RL7
      default: vec_of = VIC_VEC_EXT0;
    endcase
  endfunction

  function automatic logic [7:0] pack_c0(input vic_state_s s);
    pack_c0 = 8'h00; // bit 7 reads zero, see RL13
    pack_c0[VIC_C0_MASTER_EN] = s.master_irq_enable;
    pack_c0[VIC_C0_EXT0_EN] = s.en[0];
    pack_c0[VIC_C0_EXT1_EN] = s.en[1];
    pack_c0[VIC_C0_TMR0_EN] = s.en[2];
    pack_c0[VIC_C0_EXT0_FLAG] = s.flag[0];
    pack_c0[VIC_C0_EXT1_FLAG] = s.flag[1];
    pack_c0[VIC_C0_TMR0_FLAG] = s.flag[2];
  endfunction

  function automatic logic [7:0] pack_c1(input vic_state_s s);
    pack_c1 = 8'h00; // bits 3 and 7 read zero, see RL14
    pack_c1[VIC_C1_TMR1_EN] = s.en[3];
    pack_c1[VIC_C1_TB_EN] = s.en[4];
    pack_c1[VIC_C1_RTC_EN] = s.en[5];
    pack_c1[VIC_C1_TMR1_FLAG] = s.flag[3];
    pack_c1[VIC_C1_TB_FLAG] = s.flag[4];
    pack_c1[VIC_C1_RTC_FLAG] = s.flag[5];
  endfunction

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  assign set_ev[0] = st_r.pin_a_d & ~ext_irq_pin_a_in; // see RL1
  assign set_ev[1] = st_r.pin_b_d & ~ext_irq_pin_b_in; // see RL1
  assign set_ev[2] = timer0_ovf_in; // see RL4
  assign set_ev[3] = timer1_ovf_in; // see RL5
  assign set_ev[4] = timebase_tick_in; // see RL6
  assign set_ev[5] = rtc_tick_in; // see RL7
  assign t2_rise = phase_two_clock_in & ~st_r.t2_d;

  // eligibility: master, own enable, room on stack, no call in flight
  assign elig = (st_r.master_irq_enable && !stack_full_in && !st_r.call.req) ?
    (st_r.flag & st_r.en) : '0; // see RL12 RL17 RL18 RL19 RL8

  vic_pri_pick #(
    .N(VIC_NSRC)
  ) u_pick (
    .req_in(elig),
    .any_out(pick_any),
    .onehot_out(pick),
    .index_out(pick_idx)
  );

  assign c0 = pack_c0(st_r);
  assign c1 = pack_c1(st_r);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_a_d = ext_irq_pin_a_in;
    st_nxt.pin_b_d = ext_irq_pin_b_in;
    st_nxt.t2_d = phase_two_clock_in;
    // software write first, so hardware events below win
    if (bus_in.wr && bus_in.addr == VIC_ADDR_CTRL0) begin // see RL15
      st_nxt.master_irq_enable = bus_in.wdata[VIC_C0_MASTER_EN];
      st_nxt.en[0] = bus_in.wdata[VIC_C0_EXT0_EN];
      st_nxt.en[1] = bus_in.wdata[VIC_C0_EXT1_EN];
      st_nxt.en[2] = bus_in.wdata[VIC_C0_TMR0_EN];
      st_nxt.flag[0] = bus_in.wdata[VIC_C0_EXT0_FLAG];
      st_nxt.flag[1] = bus_in.wdata[VIC_C0_EXT1_FLAG];
      st_nxt.flag[2] = bus_in.wdata[VIC_C0_TMR0_FLAG];
    end
    if (bus_in.wr && bus_in.addr == VIC_ADDR_CTRL1) begin // see RL15
      st_nxt.en[3] = bus_in.wdata[VIC_C1_TMR1_EN];
      st_nxt.en[4] = bus_in.wdata[VIC_C1_TB_EN];
      st_nxt.en[5] = bus_in.wdata[VIC_C1_RTC_EN];
      st_nxt.flag[3] = bus_in.wdata[VIC_C1_TMR1_FLAG];
      st_nxt.flag[4] = bus_in.wdata[VIC_C1_TB_FLAG];
      st_nxt.flag[5] = bus_in.wdata[VIC_C1_RTC_FLAG];
    end
    // return re-opens service; plain return leaves master alone
    if (irq_return_instr_in) begin
      st_nxt.master_irq_enable = 1'b1; // see RL9
    end
    // sample on phase-two rising edge only
    if (t2_rise && pick_any) begin // see RL10
      st_nxt.flag = st_nxt.flag & ~pick; // see RL3 RL21
      st_nxt.master_irq_enable = 1'b0; // see RL3
      st_nxt.call.req = 1'b1;
      st_nxt.call.vector = vec_of(pick_idx);
      st_nxt.call.src = pick_idx;
    end
    // sequencer pushes only the pc, then takes the vector
    if (st_r.call.req && call_done_in) begin // see RL20
      st_nxt.call.req = 1'b0;
    end
    // a new event beats a clear in the same cycle
    st_nxt.flag = st_nxt.flag | set_ev; // see RL16 RL17
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_r <= '0;
      st_r.pin_a_d <= 1'b1;
      st_r.pin_b_d <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    unique case (bus_in.addr)
      VIC_ADDR_CTRL0: rdata_out = c0;
      VIC_ADDR_CTRL1: rdata_out = c1;
      default: rdata_out = VIC_CTRL_RESET;
    endcase
  end

  assign call_out = st_r.call;
endmodule // vic_ctrl

// ===== bench/vic_ctrl_asserts.sv
`timescale 1ns/1ps
module vic_ctrl_asserts (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire vic_pkg::vic_bus_s bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic phase_two_clock_in,
  input wire logic stack_full_in,
  input wire logic irq_return_instr_in,
  input wire logic call_done_in,
  input wire vic_pkg::vic_call_s call_out
);
  import vic_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rsv; rdata_out[7] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("top bit set");
  property p_unm;
    bus_in.addr != VIC_ADDR_CTRL0 && bus_in.addr != VIC_ADDR_CTRL1 |-> rdata_out == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_vec;
    $rose(call_out.req) |-> call_out.vector == {7'h00, call_out.src + 3'h1, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_stk; stack_full_in && !call_out.req |=> !call_out.req; endproperty
  a_stk: assert property (p_stk) else $error("full stack call");
  property p_hold; call_out.req && !call_done_in |=> call_out.req && $stable(call_out.vector);
  endproperty
  a_hold: assert property (p_hold) else $error("call dropped");
  property p_done; call_out.req && call_done_in |=> !call_out.req; endproperty
  a_done: assert property (p_done) else $error("call stuck");
  property p_mask;
    bus_in.addr == VIC_ADDR_CTRL0 && !rdata_out[0] && !bus_in.wr && !irq_return_instr_in
      |=> !$rose(call_out.req);
  endproperty
  a_mask: assert property (p_mask) else $error("masked call");
  property p_t2;
    $rose(call_out.req) |-> $past(phase_two_clock_in) && !$past(phase_two_clock_in, 2);
  endproperty
  a_t2: assert property (p_t2) else $error("off phase call");
  c_rtc: cover property ($rose(call_out.req) && call_out.src == 3'h5);
  c_ext0: cover property ($rose(call_out.req) && call_out.src == 3'h0);
  c_full: cover property (stack_full_in && !call_out.req);
endmodule // vic_ctrl_asserts

bind vic_ctrl vic_ctrl_asserts chk (.*);

// ===== bench/vic_seq_model.sv
`timescale 1ns/1ps
module vic_seq_model #(
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire vic_pkg::vic_call_s call_in,
  input wire logic slow_in,
  input wire logic pop_in,
  output logic done_out,
  output logic full_out,
  output logic t2_out
);
  int sp = 0;
  int wt = 0;
  logic push;
  // small depth so nesting fills the stack quickly
  assign full_out = (sp >= DEPTH);
  assign push = call_in.req && !done_out && wt >= (slow_in ? 3 : 0);
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      sp <= 0;
      wt <= 0;
      done_out <= 1'b0;
      t2_out <= 1'b0;
    end else begin
      t2_out <= ~t2_out;
      done_out <= push;
      wt <= (call_in.req && !push) ? wt + 1 : 0;
      // only the program counter goes on the stack
      sp <= sp + int'(push) - int'(pop_in && sp > 0);
    end
  end
endmodule // vic_seq_model

// ===== bench/vic_ctrl_tb_top.sv
`timescale 1ns/1ps
module vic_ctrl_tb_top;
  import vic_pkg::*;
  logic clk_in = 0, resetn_in = 0, ret = 0, pret = 0, pa = 1, pb = 1;
  logic [3:0] ev = 0;
  logic [7:0] rd;
  logic [31:0] seed = 32'h26dd;
  logic done, full, t2;
  vic_bus_s bus = '0;
  vic_call_s call;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  vic_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rd),
    .phase_two_clock_in(t2), .stack_full_in(full), .irq_return_instr_in(ret),
    .plain_return_instr_in(pret), .call_done_in(done), .call_out(call),
    .ext_irq_pin_a_in(pa), .ext_irq_pin_b_in(pb), .timer0_ovf_in(ev[0]),
    .timer1_ovf_in(ev[1]), .timebase_tick_in(ev[2]), .rtc_tick_in(ev[3]));
  vic_seq_model #(.DEPTH(2)) seq (.clk_in(clk_in), .resetn_in(resetn_in), .call_in(call),
    .slow_in(seed[3]), .pop_in(ret | pret), .done_out(done), .full_out(full), .t2_out(t2));
  initial forever #25 clk_in = ~clk_in;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus = '{a, 1'b1, d};
    tick();
    bus.wr = 1'b0;
    tick();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    // address moves at the usual offset, read looked at one cycle later
    bus.addr = a;
    tick();
    chk({4'h0, rd}, {4'h0, e});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [5:0] p;
    int k, w;
    tick(16);
    resetn_in = 1;
    tick();
    rdc(VIC_ADDR_CTRL0, 8'h00);
    wr(VIC_ADDR_CTRL1, 8'h8f);
    rdc(VIC_ADDR_CTRL1, 8'h07);
    wr(8'h0c, 8'hff);
    rdc(8'h0c, 8'h00);
    // corner: disabled source keeps its flag, software clears it
    wr(VIC_ADDR_CTRL1, 8'h00);
    ev = 4'h8;
    tick();
    ev = 4'h0;
    wr(VIC_ADDR_CTRL0, 8'h8f);
    tick(4);
    chk({11'h0, call.req}, 12'h0);
    rdc(VIC_ADDR_CTRL1, 8'h40);
    wr(VIC_ADDR_CTRL1, 8'h00);
    rdc(VIC_ADDR_CTRL1, 8'h00);
    wr(VIC_ADDR_CTRL1, 8'h07);
    wr(VIC_ADDR_CTRL0, 8'h8e);
    // corner: plain return leaves master enable cleared
    pret = 1;
    tick();
    pret = 0;
    rdc(VIC_ADDR_CTRL0, 8'h0e);
    rdc(VIC_ADDR_CTRL1, 8'h07);
    for (int r = 0; r < 12; r++) begin
      seed = xs(seed);
      p = (r == 0) ? 6'h3f : (seed[9:4] == 0 ? 6'h20 : seed[9:4]);
      {ev, pb, pa} = {p[5:2], ~p[1:0]};
      tick();
      {ev, pb, pa} = 6'h03;
      tick(4);
      chk({11'h0, call.req}, 12'h0);
      rdc(VIC_ADDR_CTRL0, {1'b0, p[2:0], 4'he});
      rdc(VIC_ADDR_CTRL1, {1'b0, p[5:3], 4'h7});
      while (p != 0) begin
        k = 0;
        while (!p[k]) k++;
        seed = xs(seed);
        if (seed[k] && !full) begin
          ret = 1;
          tick();
          ret = 0;
        end else wr(VIC_ADDR_CTRL0, {1'b0, p[2:0], 4'hf});
        if (full) begin
          tick(6);
          chk({11'h0, call.req}, 12'h0);
          pret = 1;
          tick();
          pret = 0;
        end
        w = 0;
        while (!call.req && w < 12) begin
          tick();
          w++;
        end
        // a missing call must not pass on a stale vector
        chk(call.req ? call.vector : 12'hfff, 12'(4 * (k + 1)));
        while (call.req) tick();
        p[k] = 1'b0;
        rdc(VIC_ADDR_CTRL0, {1'b0, p[2:0], 4'he});
        rdc(VIC_ADDR_CTRL1, {1'b0, p[5:3], 4'h7});
      end
      $display("round %0d done", r);
    end
    end_of_test();
  end
endmodule // vic_ctrl_tb_top
